/* core/fpc_ctrl.sv */
// flash program controller: apb registers, command sequencer and status polling
//
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/100ps
module fpc_ctrl
  import fpc_pkg::*;
(
  input wire logic i_sys_clk,                 // system clock, 200 MHz
  input wire logic i_rstn,                    // synchronous reset, active low
  input wire logic i_psel,                    // apb select
  input wire logic i_penable,                 // apb enable
  input wire logic i_pwrite,                  // apb direction
  input wire logic [7:0] i_paddr,             // apb byte address
  input wire logic [31:0] i_pwdata,           // apb write data
  output logic [31:0] o_prdata,               // apb read data
  output logic o_pready,                      // apb ready
  output logic o_pslverr,                     // apb error on unmapped address
  output logic [fpc_pkg::ADDR_W-1:0] o_flash_addr,   // flash address
  output logic [fpc_pkg::DATA_W-1:0] o_flash_dq,     // flash data out
  output logic o_flash_dq_oe,                 // flash data driven
  input wire logic [fpc_pkg::DATA_W-1:0] i_flash_dq, // flash data in
  output logic o_flash_ce_n,                  // flash chip enable
  output logic o_flash_we_n,                  // flash write enable
  output logic o_flash_oe_n,                  // flash output enable
  output logic o_accelerate_pin               // raise accelerate pin to high_program_level
);
  import fpc_pkg::*;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00, S_SEQ = 2'b01, S_POLL_A = 2'b10, S_POLL_B = 2'b11
  } fpc_st_e;

  typedef struct packed {
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fpc_step_s;

  typedef struct packed {
    fpc_st_e st;
    fpc_op_e op;
    logic [4:0] step;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [4:0] cnt;
    logic [BUF_WORDS-1:0][DATA_W-1:0] bufw;
    logic acc;
    logic id_mode;
    logic sec_mode;
    logic byp_mode;
    logic abort_pend;
    logic done;
    logic refused;
    logic err_time;
    logic err_abort;
    logic err_verify;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] poll1;
    logic req;
    logic wr;
    logic [ADDR_W-1:0] caddr;
    logic [DATA_W-1:0] cdata;
    logic [31:0] prdata;
  } fpc_ctrl_s;

  fpc_ctrl_s q;
  fpc_ctrl_s d;
  fpc_cyc_if u_cyc ();

  function automatic logic [ADDR_W-1:0] sector_of(input logic [ADDR_W-1:0] a);
    return {a[ADDR_W-1:SECTOR_LSB], {SECTOR_LSB{1'b0}}};
  endfunction

  // loads are formed inside the page of the start address, so no load can leave it
  function automatic logic [ADDR_W-1:0] load_addr(input logic [ADDR_W-1:0] a, input logic [3:0] idx);
    return {a[ADDR_W-1:PAGE_LSB], idx};
  endfunction

  function automatic logic [4:0] seq_len(input fpc_op_e op, input logic [4:0] cnt);
    unique case (op)
      OP_READ, OP_RESET: return 5'd1;
      OP_BYP_PROG, OP_BYP_EXIT: return 5'd2;
      OP_IDENT, OP_SEC_ENTER, OP_BYP_ENTER, OP_ABORT_RESET: return 5'd3;
      OP_SEC_EXIT, OP_PROGRAM: return 5'd4;
      OP_BUF_PROG: return cnt + 5'd6;
      default: return 5'd1;
    endcase
  endfunction

  function automatic logic is_prog(input fpc_op_e op);
    return (op == OP_PROGRAM) || (op == OP_BYP_PROG) || (op == OP_BUF_PROG);
  endfunction

  // status is read at the address loaded last
  function automatic logic [ADDR_W-1:0] poll_addr(input fpc_op_e op, input logic [ADDR_W-1:0] a,
                                                  input logic [4:0] cnt);
    return (op == OP_BUF_PROG) ? load_addr(a, cnt[3:0]) : a;
  endfunction

  function automatic fpc_step_s step_cycle(input fpc_op_e op, input logic [4:0] step,
                                           input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] dat,
                                           input logic [4:0] cnt,
                                           input logic [BUF_WORDS-1:0][DATA_W-1:0] bw);
    fpc_step_s s;
    logic [4:0] idx;
    s = '{wr: 1'b1, addr: UNLOCK1_ADDR, data: UNLOCK1_DATA};
    idx = step - 5'd4;
    unique case (op)
      OP_READ:
        s = '{wr: 1'b0, addr: a, data: dat};
      OP_RESET:
        s.data = CMD_RESET;
      OP_BYP_PROG:
        s = (step == 5'd0) ? '{wr: 1'b1, addr: a, data: CMD_PROGRAM} : '{wr: 1'b1, addr: a, data: dat};
      OP_BYP_EXIT:
        s.data = (step == 5'd0) ? CMD_BYPASS_EXIT : CMD_EXIT_TAIL;
      default:
      begin
        // unlock pair, then the op's command word
        if (step == 5'd1)
          s = '{wr: 1'b1, addr: UNLOCK2_ADDR, data: UNLOCK2_DATA};
        else if (step == 5'd2)
        begin
          unique case (op)
            OP_IDENT: s.data = CMD_IDENT;
            OP_SEC_ENTER: s.data = CMD_SEC_ENTER;
            OP_SEC_EXIT: s.data = CMD_SEC_EXIT;
            OP_PROGRAM: s.data = CMD_PROGRAM;
            OP_BYP_ENTER: s.data = CMD_BYPASS;
            OP_ABORT_RESET: s.data = CMD_ABORT_RESET;
            default: s = '{wr: 1'b1, addr: sector_of(a), data: CMD_BUF_LOAD};
          endcase
        end
        else if (step == 5'd3)
        begin
          unique case (op)
            OP_PROGRAM: s = '{wr: 1'b1, addr: a, data: dat};
            OP_SEC_EXIT: s.data = CMD_EXIT_TAIL;
            default: s = '{wr: 1'b1, addr: sector_of(a), data: {11'h000, cnt}};
          endcase
        end
        else if (step > 5'd3 && idx <= cnt)
          s = '{wr: 1'b1, addr: load_addr(a, idx[3:0]), data: bw[idx[3:0]]};
        else if (step > 5'd3)
          s = '{wr: 1'b1, addr: sector_of(a), data: CMD_BUF_CONFIRM};
      end
    endcase
    return s;
  endfunction

  always_comb
  begin
    fpc_step_s s;
    fpc_op_e nop;
    logic byp_eff;
    logic start_ok;
    logic acc_w;
    logic [DATA_W-1:0] expect_w;
    s = '0;
    d = q;
    nop = fpc_op_e'(i_pwdata[3:0]);
    byp_eff = q.byp_mode | q.acc;
    acc_w = i_psel & i_penable & i_pwrite;
    expect_w = (q.op == OP_BUF_PROG) ? q.bufw[q.cnt[3:0]] : q.data;

    // commands are refused while busy, when the mode forbids them, or while an abort awaits its reset
    start_ok = (q.st == S_IDLE) && (i_pwdata[3:0] <= 4'hA);
    if (q.abort_pend && nop != OP_ABORT_RESET)
      start_ok = 1'b0;
    if (byp_eff && !(nop inside {OP_BYP_PROG, OP_BYP_EXIT, OP_BUF_PROG, OP_ABORT_RESET, OP_READ}))
      start_ok = 1'b0;
    if (!byp_eff && (nop == OP_BYP_PROG || nop == OP_BYP_EXIT))
      start_ok = 1'b0;
    if (q.sec_mode && nop == OP_BYP_ENTER)
      start_ok = 1'b0;
    if (nop == OP_BUF_PROG && q.cnt >= 5'(BUF_WORDS))
      start_ok = 1'b0;

    if (i_psel && !i_penable)
    begin
      d.prdata = '0;
      unique case (i_paddr)
        REG_CMD: d.prdata = {28'h0, q.op};
        REG_ADDR: d.prdata = {10'h000, q.addr};
        REG_DATA: d.prdata = {16'h0000, q.data};
        REG_COUNT: d.prdata = {27'h0, q.cnt};
        REG_STATUS: d.prdata = {19'h0, q.abort_pend, q.acc, byp_eff, q.sec_mode, q.id_mode, 2'b00,
                                q.err_verify, q.err_abort, q.err_time, q.refused, q.done, q.st != S_IDLE};
        REG_RDATA: d.prdata = {16'h0000, q.rdata};
        REG_ACCEL: d.prdata = {31'h0, q.acc};
        default:
          if (i_paddr[7:6] == REG_BUF_PAGE)
            d.prdata = {16'h0000, q.bufw[i_paddr[5:2]]};
      endcase
    end

    if (acc_w)
    begin
      // operands are frozen while a sequence runs
      if (q.st == S_IDLE)
      begin
        if (i_paddr == REG_ADDR)
          d.addr = i_pwdata[ADDR_W-1:0];
        if (i_paddr == REG_DATA)
          d.data = i_pwdata[DATA_W-1:0];
        if (i_paddr == REG_COUNT)
          d.cnt = i_pwdata[4:0];
        if (i_paddr[7:6] == REG_BUF_PAGE)
          d.bufw[i_paddr[5:2]] = i_pwdata[DATA_W-1:0];
      end
      if (i_paddr == REG_ACCEL)
      begin
        if (q.sec_mode && i_pwdata[0])
          d.refused = 1'b1;
        else
          d.acc = i_pwdata[0];
      end
      if (i_paddr == REG_STATUS)
        {d.err_verify, d.err_abort, d.err_time, d.refused, d.done} =
          {q.err_verify, q.err_abort, q.err_time, q.refused, q.done} & ~(i_pwdata[5:1] & STATUS_W1C);
      if (i_paddr == REG_CMD)
      begin
        if (start_ok)
        begin
          s = step_cycle(nop, 5'd0, q.addr, q.data, q.cnt, q.bufw);
          d.op = nop;
          d.step = 5'd0;
          d.req = 1'b1;
          d.wr = s.wr;
          d.caddr = s.addr;
          d.cdata = s.data;
          d.st = S_SEQ;
        end
        else
          d.refused = 1'b1;
      end
    end

    // hardware events last, so a flag set in the cycle of its clear survives
    unique case (q.st)
      S_IDLE:
        d.req = d.req;
      S_SEQ:
        if (u_cyc.done)
        begin
          if (q.op == OP_READ)
            d.rdata = u_cyc.rdata;
          if (q.step == seq_len(q.op, q.cnt) - 5'd1)
          begin
            if (is_prog(q.op))
            begin
              d.wr = 1'b0;
              d.caddr = poll_addr(q.op, q.addr, q.cnt);
              d.st = S_POLL_A;
            end
            else
            begin
              d.req = 1'b0;
              d.done = 1'b1;
              d.st = S_IDLE;
              unique case (q.op)
                OP_IDENT: d.id_mode = 1'b1;
                OP_RESET: d.id_mode = 1'b0;
                OP_SEC_ENTER: d.sec_mode = 1'b1;
                OP_SEC_EXIT: d.sec_mode = 1'b0;
                OP_BYP_ENTER: d.byp_mode = 1'b1;
                OP_BYP_EXIT: d.byp_mode = 1'b0;
                OP_ABORT_RESET: d.abort_pend = 1'b0;
                default: d.done = 1'b1;
              endcase
            end
          end
          else
          begin
            d.step = q.step + 5'd1;
            s = step_cycle(q.op, d.step, q.addr, q.data, q.cnt, q.bufw);
            d.wr = s.wr;
            d.caddr = s.addr;
            d.cdata = s.data;
          end
        end
      S_POLL_A:
        if (u_cyc.done)
        begin
          d.poll1 = u_cyc.rdata;
          d.st = S_POLL_B;
        end
      S_POLL_B:
        if (u_cyc.done)
        begin
          d.rdata = u_cyc.rdata;
          if (u_cyc.rdata[TOGGLE_BIT] == q.poll1[TOGGLE_BIT])
          begin
            // toggling stopped: the cell is read back; a 1 that stayed 0 fails here
            d.req = 1'b0;
            d.done = 1'b1;
            d.st = S_IDLE;
            if (u_cyc.rdata != expect_w)
              d.err_verify = 1'b1;
          end
          else if (u_cyc.rdata[TIME_LIMIT_FLAG])
          begin
            d.req = 1'b0;
            d.err_time = 1'b1;
            d.st = S_IDLE;
          end
          else if (q.op == OP_BUF_PROG && u_cyc.rdata[BUFFER_ABORT_FLAG])
          begin
            d.req = 1'b0;
            d.err_abort = 1'b1;
            d.abort_pend = 1'b1;
            d.st = S_IDLE;
          end
          else
            d.st = S_POLL_A;
        end
    endcase
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rstn)
      q <= '0;
    else
      q <= d;
  end

  assign u_cyc.req = q.req;
  assign u_cyc.wr = q.wr;
  assign u_cyc.addr = q.caddr;
  assign u_cyc.wdata = q.cdata;

  fpc_cycle u_engine (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .cyc(u_cyc),
    .i_dq(i_flash_dq),
    .o_addr(o_flash_addr),
    .o_dq(o_flash_dq),
    .o_dq_oe(o_flash_dq_oe),
    .o_ce_n(o_flash_ce_n),
    .o_we_n(o_flash_we_n),
    .o_oe_n(o_flash_oe_n)
  );

  assign o_prdata = q.prdata;
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~(i_paddr inside {REG_CMD, REG_ADDR, REG_DATA, REG_COUNT,
                     REG_STATUS, REG_RDATA, REG_ACCEL} || i_paddr[7:6] == REG_BUF_PAGE);
  assign o_accelerate_pin = q.acc;
endmodule

/* pkg/fpc_pkg.sv */
// constants, command codes and register map of the flash program controller
package fpc_pkg;
  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;
  localparam int BUF_WORDS = 16;
  localparam int PAGE_LSB = 4;
  localparam int SECTOR_LSB = 15;

  localparam int CLK_PERIOD_NS = 5;
  localparam int T_ADDR_SETUP_NS = 10;
  localparam int T_WE_PULSE_NS = 35;
  localparam int T_READ_ACC_NS = 90;
  localparam int T_HOLD_NS = 5;
  localparam int T_GAP_NS = 30;
  function automatic int ns2cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam logic [4:0] C_ADDR_SETUP = 5'(ns2cyc(T_ADDR_SETUP_NS));
  localparam logic [4:0] C_WE_PULSE = 5'(ns2cyc(T_WE_PULSE_NS));
  localparam logic [4:0] C_READ_ACC = 5'(ns2cyc(T_READ_ACC_NS));
  localparam logic [4:0] C_HOLD = 5'(ns2cyc(T_HOLD_NS));
  localparam logic [4:0] C_GAP = 5'(ns2cyc(T_GAP_NS));

  // command table values; replace from the part's published table
  localparam logic [ADDR_W-1:0] UNLOCK1_ADDR = 22'h000555;
  localparam logic [ADDR_W-1:0] UNLOCK2_ADDR = 22'h0002AA;
  localparam logic [DATA_W-1:0] UNLOCK1_DATA = 16'h00AA;
  localparam logic [DATA_W-1:0] UNLOCK2_DATA = 16'h0055;
  localparam logic [DATA_W-1:0] CMD_RESET = 16'h00F0;
  localparam logic [DATA_W-1:0] CMD_IDENT = 16'h0090;
  localparam logic [DATA_W-1:0] CMD_SEC_ENTER = 16'h0088;
  localparam logic [DATA_W-1:0] CMD_SEC_EXIT = 16'h0090;
  localparam logic [DATA_W-1:0] CMD_EXIT_TAIL = 16'h0000;
  localparam logic [DATA_W-1:0] CMD_PROGRAM = 16'h00A0;
  localparam logic [DATA_W-1:0] CMD_BYPASS = 16'h0020;
  localparam logic [DATA_W-1:0] CMD_BYPASS_EXIT = 16'h0090;
  localparam logic [DATA_W-1:0] CMD_BUF_LOAD = 16'h0025;
  localparam logic [DATA_W-1:0] CMD_BUF_CONFIRM = 16'h0029;
  localparam logic [DATA_W-1:0] CMD_ABORT_RESET = 16'h00F0;

  localparam int DATA_POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int TIME_LIMIT_FLAG = 5;
  localparam int BUFFER_ABORT_FLAG = 1;

  typedef enum logic [3:0] {
    OP_READ = 4'h0, OP_RESET = 4'h1, OP_IDENT = 4'h2, OP_SEC_ENTER = 4'h3,
    OP_SEC_EXIT = 4'h4, OP_PROGRAM = 4'h5, OP_BYP_ENTER = 4'h6, OP_BYP_PROG = 4'h7,
    OP_BYP_EXIT = 4'h8, OP_BUF_PROG = 4'h9, OP_ABORT_RESET = 4'hA
  } fpc_op_e;

  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam logic [7:0] REG_COUNT = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_RDATA = 8'h14;
  localparam logic [7:0] REG_ACCEL = 8'h18;
  localparam logic [1:0] REG_BUF_PAGE = 2'h1;
  localparam logic [4:0] STATUS_W1C = 5'h1F;
  localparam logic PIN_IDLE = 1'b1;
endpackage

/* pkg/fpc_cyc_if.sv */
// one flash bus cycle request and its answer, between sequencer and pin engine
`timescale 1ns/100ps
interface fpc_cyc_if;
  logic req;
  logic wr;
  logic [fpc_pkg::ADDR_W-1:0] addr;
  logic [fpc_pkg::DATA_W-1:0] wdata;
  logic done;
  logic [fpc_pkg::DATA_W-1:0] rdata;
  modport ctrl (output req, wr, addr, wdata, input done, rdata);
  modport eng (input req, wr, addr, wdata, output done, rdata);
endinterface

/* core/fpc_cycle.sv */
// pin engine: runs one write or read cycle on the flash pins
`timescale 1ns/100ps
module fpc_cycle
  import fpc_pkg::*;
(
  input wire logic i_sys_clk,             // system clock
  input wire logic i_rstn,                // synchronous reset, active low
  fpc_cyc_if.eng cyc,                     // cycle request from sequencer
  input wire logic [fpc_pkg::DATA_W-1:0] i_dq, // flash data in
  output logic [fpc_pkg::ADDR_W-1:0] o_addr,   // flash address
  output logic [fpc_pkg::DATA_W-1:0] o_dq,     // flash data out
  output logic o_dq_oe,                   // data bus driven
  output logic o_ce_n,                    // chip enable, low active
  output logic o_we_n,                    // write enable, low active
  output logic o_oe_n                     // output enable, low active
);
  import fpc_pkg::*;

  typedef enum logic [2:0] {
    PH_IDLE = 3'b000, PH_SETUP = 3'b001, PH_STROBE = 3'b010, PH_HOLD = 3'b011, PH_GAP = 3'b100
  } fpc_ph_e;

  typedef struct packed {
    fpc_ph_e ph;
    logic [4:0] cnt;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq;
    logic dq_oe;
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic done;
    logic [DATA_W-1:0] rdata;
  } fpc_eng_s;

  fpc_eng_s q;
  fpc_eng_s d;

  always_comb
  begin
    d = q;
    d.done = 1'b0;
    if (q.cnt != 5'h00)
      d.cnt = q.cnt - 5'h01;
    unique case (q.ph)
      PH_IDLE:
        if (cyc.req)
        begin
          // chip enable and address first; we falls later, so the address is taken then
          d.wr = cyc.wr;
          d.addr = cyc.addr;
          d.dq = cyc.wdata;
          d.dq_oe = cyc.wr;
          d.ce_n = 1'b0;
          d.cnt = C_ADDR_SETUP - 5'h01;
          d.ph = PH_SETUP;
        end
      PH_SETUP:
        if (q.cnt == 5'h00)
        begin
          d.we_n = ~q.wr;
          d.oe_n = q.wr;
          d.cnt = q.wr ? C_WE_PULSE - 5'h01 : C_READ_ACC - 5'h01;
          d.ph = PH_STROBE;
        end
      PH_STROBE:
        if (q.cnt == 5'h00)
        begin
          // we rises before ce, so data is taken on this edge
          d.we_n = PIN_IDLE;
          d.oe_n = PIN_IDLE;
          if (!q.wr)
            d.rdata = i_dq;
          d.cnt = C_HOLD - 5'h01;
          d.ph = PH_HOLD;
        end
      PH_HOLD:
        if (q.cnt == 5'h00)
        begin
          d.ce_n = PIN_IDLE;
          d.dq_oe = 1'b0;
          d.done = 1'b1;
          d.cnt = C_GAP - 5'h01;
          d.ph = PH_GAP;
        end
      PH_GAP:
        if (q.cnt == 5'h00)
          d.ph = PH_IDLE;
      default:
        d.ph = PH_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rstn)
    begin
      q <= '0;
      q.ce_n <= PIN_IDLE;
      q.we_n <= PIN_IDLE;
      q.oe_n <= PIN_IDLE;
    end
    else
      q <= d;
  end

  assign cyc.done = q.done;
  assign cyc.rdata = q.rdata;
  assign o_addr = q.addr;
  assign o_dq = q.dq;
  assign o_dq_oe = q.dq_oe;
  assign o_ce_n = q.ce_n;
  assign o_we_n = q.we_n;
  assign o_oe_n = q.oe_n;
endmodule

/* tb/fpc_ctrl_assertions.sv */
// concurrent checks on the controller ports
`timescale 1ns/100ps
module fpc_ctrl_assertions
  import fpc_pkg::*;
(
  input wire logic i_sys_clk, // clock
  input wire logic i_rstn, // reset
  input wire logic i_psel, // apb
  input wire logic i_penable, // apb
  input wire logic i_pwrite, // apb
  input wire logic [7:0] i_paddr, // apb
  input wire logic [31:0] i_pwdata, // apb
  input wire logic o_pready, // apb
  input wire logic o_pslverr, // apb
  input wire logic [fpc_pkg::ADDR_W-1:0] o_flash_addr, // flash
  input wire logic [fpc_pkg::DATA_W-1:0] o_flash_dq, // flash
  input wire logic o_flash_dq_oe, // flash
  input wire logic o_flash_ce_n, // flash
  input wire logic o_flash_we_n, // flash
  input wire logic o_flash_oe_n, // flash
  input wire logic o_accelerate_pin // flash
);
  import fpc_pkg::*;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  ready_high_a: assert property (o_pready) else $error("pready low");
  err_access_a: assert property (o_pslverr |-> i_psel && i_penable) else $error("stray pslverr");
  we_framed_a: assert property (!o_flash_we_n |-> !o_flash_ce_n && o_flash_dq_oe && o_flash_oe_n)
    else $error("write strobe outside cycle");
  addr_hold_a: assert property (!o_flash_ce_n && $past(!o_flash_ce_n) |-> $stable(o_flash_addr))
    else $error("address moved in cycle");
  data_hold_a: assert property (o_flash_dq_oe && $past(o_flash_dq_oe) |-> $stable(o_flash_dq))
    else $error("data moved in write");
  we_pulse_a: assert property ($fell(o_flash_we_n) |-> !o_flash_we_n [*7] ##1 o_flash_we_n)
    else $error("write pulse length");
  read_float_a: assert property (!o_flash_oe_n |-> !o_flash_dq_oe) else $error("bus fight");
  accel_cause_a: assert property ($rose(o_accelerate_pin) |->
    $past(i_psel && i_penable && i_pwrite && i_paddr == REG_ACCEL && i_pwdata[0])) else $error("accel rose");
endmodule

/* tb/fpc_flash_model.sv */
// behavioural flash on the far side of the controller
`timescale 1ns/100ps
module fpc_flash_model
  import fpc_pkg::*;
#(
  parameter logic [15:0] MAKER = 16'h0001, // arbitrary
  parameter logic [15:0] DEV = 16'h0100 // arbitrary
)
(
  input wire logic [fpc_pkg::ADDR_W-1:0] i_addr, // address
  input wire logic [fpc_pkg::DATA_W-1:0] i_dq, // host data
  input wire logic i_ce_n, // chip enable
  input wire logic i_we_n, // write strobe
  input wire logic i_oe_n, // read strobe
  input wire logic i_acc, // accelerate pin
  output logic [fpc_pkg::DATA_W-1:0] o_dq // data to host
);
  import fpc_pkg::*;
  logic [15:0] mem [int];
  logic [15:0] bq [int];
  logic [ADDR_W-1:0] la = 0;
  logic [ADDR_W-1:PAGE_LSB] pg = 0;
  logic [15:0] rd = 0, ld = 0;
  int st = 0, busy = 0, cnt = 0, nl = 0;
  logic id = 0, sec = 0, byp = 0, abt = 0, tog = 0;
  function automatic logic [15:0] rdm(input int a);
    return mem.exists(a) ? mem[a] : 16'hFFFF;
  endfunction
  always @(negedge i_we_n) if (!i_ce_n) la = i_addr;
  always @(posedge i_we_n)
  begin
    if (!i_ce_n && busy == 0)
    begin
      case (st)
        0: if (la == UNLOCK1_ADDR && i_dq == UNLOCK1_DATA) st = 1;
           else if ((byp || i_acc) && i_dq == CMD_PROGRAM) st = 5;
           else if ((byp || i_acc) && i_dq == CMD_BYPASS_EXIT) st = 6;
           else if (i_dq == CMD_RESET) id = 0;
        1: st = (la == UNLOCK2_ADDR && i_dq == UNLOCK2_DATA) ? 2 : 0;
        2:
        begin
          st = i_dq == CMD_PROGRAM ? 5 : i_dq == CMD_BUF_LOAD ? 7 : (i_dq == CMD_IDENT && sec) ? 6 : 0;
          id |= i_dq == CMD_IDENT && !sec;
          sec |= i_dq == CMD_SEC_ENTER;
          byp |= i_dq == CMD_BYPASS && !sec;
          abt &= i_dq != CMD_ABORT_RESET;
        end
        5:
        begin
          mem[la] = rdm(la) & i_dq;
          ld = i_dq;
          busy = 4;
          st = 0;
        end
        6:
        begin
          if (i_dq == CMD_EXIT_TAIL && sec) sec = 0;
          else if (i_dq == CMD_EXIT_TAIL) byp = 0;
          st = 0;
        end
        7:
        begin
          cnt = i_dq;
          nl = 0;
          bq.delete();
          abt = cnt >= BUF_WORDS;
          st = abt ? 0 : 8;
        end
        8:
        begin
          if (nl == 0) pg = la[ADDR_W-1:PAGE_LSB];
          abt = la[ADDR_W-1:PAGE_LSB] != pg;
          bq[la] = i_dq;
          ld = i_dq;
          nl++;
          st = abt ? 0 : nl > cnt ? 9 : 8;
        end
        default:
        begin
          abt = i_dq != CMD_BUF_CONFIRM || la[ADDR_W-1:SECTOR_LSB] != pg[ADDR_W-1:SECTOR_LSB];
          if (!abt) foreach (bq[k]) mem[k] = rdm(k) & bq[k];
          busy = abt ? 0 : 4;
          st = 0;
        end
      endcase
    end
  end
  // status replaces array data while busy or after an abort
  always @(negedge i_oe_n)
    if (!i_ce_n)
      rd = (busy > 0 || abt) ? 16'({~ld[7], tog, 4'h0, abt, 1'b0}) : !id ? rdm(i_addr)
         : i_addr[7:0] == 0 ? MAKER : i_addr[7:0] == 1 ? DEV : i_addr[7:1] == 7 ? DEV + i_addr[0] + 1 : 0;
  always @(posedge i_oe_n)
    if (busy > 0 || abt)
    begin
      tog = !tog;
      if (busy > 0) busy--;
    end
  // released bus shows the inverse so a stale value never passes
  assign o_dq = (!i_ce_n && !i_oe_n) ? rd : ~rd;
endmodule

/* tb/tb.sv */
// self-checking bench for the flash program controller
`timescale 1ns/100ps
module tb;
  import fpc_pkg::*;
  localparam logic [15:0] MK = 16'h0A3C; // arbitrary
  localparam logic [15:0] DV = 16'h2E10; // arbitrary
  logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, perr = 0;
  logic pready, pslverr, dq_oe, ce_n, we_n, oe_n, acc;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r = 0, seed = 32'h30507FF8;
  logic [ADDR_W-1:0] fa, a;
  logic [DATA_W-1:0] fdq, fin, d;
  logic [15:0] em [int];
  int error_cnt = 0, n_checks = 0, cyc = 0, n;
  fpc_ctrl dut_u (.i_sys_clk(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .o_flash_addr(fa), .o_flash_dq(fdq), .o_flash_dq_oe(dq_oe), .i_flash_dq(fin), .o_flash_ce_n(ce_n),
    .o_flash_we_n(we_n), .o_flash_oe_n(oe_n), .o_accelerate_pin(acc));
  fpc_flash_model #(.MAKER(MK), .DEV(DV)) mdl_u (.i_addr(fa), .i_dq(fdq), .i_ce_n(ce_n), .i_we_n(we_n),
    .i_oe_n(oe_n), .i_acc(acc), .o_dq(fin));
  initial forever #2.5 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      error_cnt++;
      conclude();
    end
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [15:0] ex(input int k);
    return em.exists(k) ? em[k] : 16'hFFFF;
  endfunction
  function automatic void pe(input int k, input logic [15:0] v);
    em[k] = ex(k) & v;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    psel <= 1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    perr = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  // clears sticky flags, starts an op and polls until idle
  task automatic op(input fpc_op_e c, input logic [21:0] k, input logic [15:0] v);
    apb(1, REG_STATUS, 32'h3E);
    apb(1, REG_ADDR, 32'(k));
    apb(1, REG_DATA, 32'(v));
    apb(1, REG_CMD, 32'(c));
    do apb(0, REG_STATUS, 0); while (r[0] !== 1'b0);
  endtask
  task automatic rd(input logic [21:0] k);
    op(OP_READ, k, 0);
    apb(0, REG_RDATA, 0);
  endtask
  task automatic prog(input fpc_op_e c);
    a = ADDR_W'(rnd());
    d = DATA_W'(rnd());
    op(c, a, d);
    pe(a, d);
    rd(a);
    chk(r, ex(a));
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    rstn <= 1;
    @(posedge clk);
    apb(0, REG_STATUS, 0);
    chk(r, 0);
    apb(0, 8'h20, 0);
    chk(perr, 1);
    $display("registers done");
    op(OP_IDENT, 0, 0);
    chk(r[8], 1);
    for (int k = 0; k < 4; k++)
    begin
      rd(k < 2 ? k : k + 12);
      chk(r, k == 0 ? MK : DV + k - 1);
    end
    op(OP_RESET, 0, 0);
    chk(r[8], 0);
    rd(1);
    chk(r, ex(1));
    $display("identifier done");
    repeat (4) prog(OP_PROGRAM);
    op(OP_PROGRAM, a, ~d);
    pe(a, ~d);
    chk(r[5], 32'(ex(a) != DATA_W'(~d)));
    rd(a);
    chk(r, ex(a));
    $display("program done");
    op(OP_BYP_ENTER, 0, 0);
    chk(r[10], 1);
    op(OP_PROGRAM, 0, 0);
    chk(r[2], 1);
    repeat (3) prog(OP_BYP_PROG);
    op(OP_BYP_EXIT, 0, 0);
    chk(r[10], 0);
    $display("bypass done");
    op(OP_SEC_ENTER, 0, 0);
    chk(r[9], 1);
    op(OP_BYP_ENTER, 0, 0);
    chk(r[2], 1);
    apb(1, REG_ACCEL, 1);
    chk(acc, 0);
    op(OP_SEC_EXIT, 0, 0);
    chk(r[9], 0);
    $display("serial region done");
    for (int t = 0; t < 2; t++)
    begin
      n = t ? rnd() % 15 : 15;
      a = ADDR_W'(rnd()) & ~22'hF;
      for (int i = 0; i <= n; i++)
      begin
        d = DATA_W'(rnd());
        apb(1, 8'(8'h40 + 4 * i), 32'(d));
        pe(a | i, d);
      end
      apb(1, REG_COUNT, n);
      op(OP_BUF_PROG, a, 0);
      chk(r[4:1], 4'h1);
      for (int i = 0; i <= n; i++)
      begin
        rd(a | i);
        chk(r, ex(a | i));
      end
    end
    apb(1, REG_COUNT, 16);
    op(OP_BUF_PROG, a, 0);
    chk(r[2], 1);
    op(OP_ABORT_RESET, 0, 0);
    chk(r[12:1], 12'h001);
    $display("buffer done");
    apb(1, REG_ACCEL, 1);
    chk(acc, 1);
    prog(OP_BYP_PROG);
    apb(1, REG_ACCEL, 0);
    chk(acc, 0);
    $display("accelerate done");
    conclude();
  end
endmodule
bind fpc_ctrl fpc_ctrl_assertions chk_u (.*);
